// file: dca_top.sv
// example peripheral with a read and a write dma channel and a ram-port arbiter
// assumes a plain register port, read data one cycle after the strobe
//
// Local design decisions: strobed register access and the address map.
module dca_top
   import dca_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [dca_pkg::DW-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [dca_pkg::DW-1:0] o_rdata,
   // peripheral core: bytes read from ram
   output logic o_rd_valid,
   output logic [7:0] o_rd_byte,
   // peripheral core: bytes to write to ram
   input wire logic i_wr_valid,
   input wire logic [7:0] i_wr_byte,
   input wire logic i_wr_end,
   output logic o_wr_ready,
   // other masters of the matrix, one request per priority level
   input wire logic [dca_pkg::NPRI-1:0] i_oth_req,
   input wire logic [dca_pkg::NPRI-1:0] i_oth_active,
   output logic [dca_pkg::NPRI-1:0] o_oth_gnt,
   // ram slave port
   output logic [1:0] o_htrans,
   output logic [dca_pkg::AW-1:0] o_haddr,
   output logic o_hwrite,
   output logic [2:0] o_hsize,
   output logic [7:0] o_hwdata,
   input wire logic [7:0] i_hrdata,
   // events
   output logic o_rd_done,
   output logic o_wr_done,
   output logic o_wr_lost
);
   import dca_pkg::*;
   typedef struct packed {
      logic [AW-1:0] rptr;
      logic [CW-1:0] rmax;
      logic rlist;
      logic [AW-1:0] wptr;
      logic [CW-1:0] wmax;
      logic drop;
      logic rstart;
      logic wstart;
      logic [DW-1:0] rdata;
      logic [NPRI-1:0] oth_gnt;
      logic [1:0] htrans;
      logic [AW-1:0] haddr;
      logic hwrite;
      logic [7:0] hwdata;
      logic rd_valid;
      logic rv_p;
      logic [7:0] rd_byte;
      logic wr_ready;
      logic rd_done;
      logic wr_done;
      logic wr_lost;
   } dca_top_s_t;
   dca_top_s_t s_q, s_d;
   // ----------------------------------------------------------------
   // channel instances
   // ----------------------------------------------------------------
   logic r_req, w_req, r_busy, w_busy, r_done, w_done, w_lost, r_rv, w_pready;
   logic [AW-1:0] r_haddr, w_haddr;
   logic [7:0] r_rbyte, w_hwdata;
   logic [CW-1:0] r_amt, w_amt;
   logic [NPRI-1:0] arb_req, arb_act, arb_gnt;
   logic r_gnt, w_gnt, r_turn;
   // one serial-level master; read and write channels take turns
   assign r_turn = r_req && !(w_req && r_busy && s_q.hwrite);
   assign r_gnt = arb_gnt[PRI_SERIAL] && r_turn;
   assign w_gnt = arb_gnt[PRI_SERIAL] && !r_turn && w_req;
   dca_channel u_rd (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_dir(1'b0), .i_list_cap(1'b1),
      .i_list_en(s_q.rlist), .i_ptr(s_q.rptr), .i_max(s_q.rmax),
      .i_start(s_q.rstart), .i_drop(1'b0), .i_pv(1'b0), .i_pdata(8'h00),
      .i_pend(1'b0), .o_pready(), .o_rv(r_rv), .o_rdata(r_rbyte),
      .o_req(r_req), .i_gnt(r_gnt), .o_haddr(r_haddr), .o_hwrite(),
      .o_hwdata(), .i_hrdata(i_hrdata), .o_busy(r_busy), .o_done(r_done),
      .o_lost(), .o_transferred_count(r_amt)
   );
   dca_channel u_wr (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_dir(1'b1), .i_list_cap(1'b0),
      .i_list_en(1'b0), .i_ptr(s_q.wptr), .i_max(s_q.wmax),
      .i_start(s_q.wstart), .i_drop(s_q.drop), .i_pv(i_wr_valid),
      .i_pdata(i_wr_byte), .i_pend(i_wr_end), .o_pready(w_pready), .o_rv(),
      .o_rdata(), .o_req(w_req), .i_gnt(w_gnt), .o_haddr(w_haddr),
      .o_hwrite(), .o_hwdata(w_hwdata), .i_hrdata(i_hrdata), .o_busy(w_busy),
      .o_done(w_done), .o_lost(w_lost), .o_transferred_count(w_amt)
   );
   // ----------------------------------------------------------------
   // arbitration of the ram port
   // ----------------------------------------------------------------
   always_comb begin
      arb_req = i_oth_req;
      arb_act = i_oth_active;
      arb_req[PRI_SERIAL] = r_req || w_req;
      arb_act[PRI_SERIAL] = r_req || w_req;
   end
   dca_arbiter u_arb (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(arb_req), .i_active(arb_act),
      .o_gnt(arb_gnt)
   );
   // ----------------------------------------------------------------
   // registers and output stage
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rstart = 1'b0;
      s_d.wstart = 1'b0;
      s_d.rdata = '0;
      if (i_wr) begin
         unique case (i_addr)
            RD_PTR_OFS: s_d.rptr = i_wdata;
            RD_MAX_OFS: s_d.rmax = i_wdata[CW-1:0];
            RD_LIST_OFS: s_d.rlist = i_wdata[LIST_EN_BIT];
            WR_PTR_OFS: s_d.wptr = i_wdata;
            WR_MAX_OFS: s_d.wmax = i_wdata[CW-1:0];
            CTRL_OFS: begin
               s_d.rstart = i_wdata[CTRL_RD_START_BIT] && !r_busy;
               s_d.wstart = i_wdata[CTRL_WR_START_BIT] && !w_busy;
               s_d.drop = i_wdata[CTRL_DROP_BIT];
            end
            default: ;
         endcase
      end
      if (i_rd) begin
         unique case (i_addr)
            RD_PTR_OFS: s_d.rdata = s_q.rptr;
            RD_MAX_OFS: s_d.rdata = DW'(s_q.rmax);
            RD_AMT_OFS: s_d.rdata = DW'(r_amt);
            RD_LIST_OFS: s_d.rdata = DW'(s_q.rlist);
            WR_PTR_OFS: s_d.rdata = s_q.wptr;
            WR_MAX_OFS: s_d.rdata = DW'(s_q.wmax);
            WR_AMT_OFS: s_d.rdata = DW'(w_amt);
            CTRL_OFS: s_d.rdata = DW'(s_q.drop) << CTRL_DROP_BIT;
            STAT_OFS: s_d.rdata = DW'({w_busy, r_busy});
            default: s_d.rdata = '0;
         endcase
      end
      s_d.oth_gnt = arb_gnt;
      s_d.oth_gnt[PRI_SERIAL] = 1'b0;
      s_d.htrans = (r_gnt || w_gnt) ? HTRANS_NONSEQ : HTRANS_IDLE;
      s_d.haddr = r_gnt ? r_haddr : w_haddr;
      s_d.hwrite = w_gnt;
      s_d.hwdata = w_hwdata;
      s_d.rv_p = r_rv;
      s_d.rd_valid = s_q.rv_p;
      s_d.rd_byte = s_q.rv_p ? r_rbyte : s_q.rd_byte;
      s_d.wr_ready = w_pready;
      s_d.rd_done = r_done;
      s_d.wr_done = w_done;
      s_d.wr_lost = w_lost;
      if (!i_rst_n) begin
         s_d = '0;
         s_d.rptr = PTR_RST;
         s_d.wptr = PTR_RST;
         s_d.rmax = CNT_RST;
         s_d.wmax = CNT_RST;
      end
   end
   always_ff @(posedge i_clk) begin
      s_q <= s_d;
   end
   assign o_rdata = s_q.rdata;
   assign o_oth_gnt = s_q.oth_gnt;
   assign o_htrans = s_q.htrans;
   assign o_haddr = s_q.haddr;
   assign o_hwrite = s_q.hwrite;
   assign o_hsize = HSIZE_BYTE;
   assign o_hwdata = s_q.hwdata;
   assign o_rd_valid = s_q.rd_valid;
   assign o_rd_byte = s_q.rd_byte;
   assign o_wr_ready = s_q.wr_ready;
   assign o_rd_done = s_q.rd_done;
   assign o_wr_done = s_q.wr_done;
   assign o_wr_lost = s_q.wr_lost;
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_ram_only: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_htrans == HTRANS_NONSEQ |-> o_haddr >= RAM_BASE && o_haddr <= RAM_LIMIT)
      else $error("access outside ram");
   a_hi_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      arb_req[PRI_CPU] && arb_gnt == '0 |=> arb_gnt[PRI_CPU])
      else $error("cpu not granted first");
   a_lo_stall: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      arb_gnt[PRI_CPU] && arb_req[PRI_CPU] && arb_act[PRI_CPU] |=> !arb_gnt[PRI_SERIAL])
      else $error("lower master not stalled");
   a_pause_lend: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      arb_gnt[PRI_CPU] && !arb_req[PRI_CPU] && arb_req[PRI_SERIAL]
      && arb_req[PRI_RADIO] |=> arb_gnt[PRI_SERIAL])
      else $error("paused slot not lent");
   a_ser_excl: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !(r_gnt && w_gnt)) else $error("serial level double use");
   a_wr_max: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      w_done |-> w_amt <= s_q.wmax) else $error("write count over maximum");
   a_done_amt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      r_done && !s_q.rlist |=> o_rd_done && $stable(r_amt))
      else $error("done pulse not aligned with count");
   a_rd_bytes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      r_gnt |=> ##2 o_rd_valid) else $error("read byte not delivered");
endmodule

// file: dca_pkg.sv
// package for the dma channel and ahb arbiter block
// assumes one 125 MHz clock and synchronous active-low reset
package dca_pkg;
   // ----------------------------------------------------------------
   // widths and counts
   // ----------------------------------------------------------------
   localparam int AW = 32;
   localparam int DW = 32;
   localparam int CW = 16;
   localparam int NM = 9;
   localparam int NPRI = 9;
   localparam int PW = 4;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] RD_PTR_OFS = 8'h00;
   localparam logic [7:0] RD_MAX_OFS = 8'h04;
   localparam logic [7:0] RD_AMT_OFS = 8'h08;
   localparam logic [7:0] RD_LIST_OFS = 8'h0C;
   localparam logic [7:0] WR_PTR_OFS = 8'h10;
   localparam logic [7:0] WR_MAX_OFS = 8'h14;
   localparam logic [7:0] WR_AMT_OFS = 8'h18;
   localparam logic [7:0] CTRL_OFS = 8'h1C;
   localparam logic [7:0] STAT_OFS = 8'h20;
   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_RD_START_BIT = 0;
   localparam int CTRL_WR_START_BIT = 1;
   localparam int CTRL_DROP_BIT = 2;
   localparam int LIST_EN_BIT = 0;
   localparam logic [AW-1:0] PTR_RST = 32'h0000_0000;
   localparam logic [CW-1:0] CNT_RST = 16'h0000;
   // ram window reachable by the channels
   localparam logic [AW-1:0] RAM_BASE = 32'h2000_0000;
   localparam logic [AW-1:0] RAM_LIMIT = 32'h2000_FFFF;
   // ----------------------------------------------------------------
   // master priority levels, 0 is highest
   // ----------------------------------------------------------------
   localparam logic [PW-1:0] PRI_CPU = 4'h0;
   localparam logic [PW-1:0] PRI_SERIAL = 4'h1;
   localparam logic [PW-1:0] PRI_RADIO = 4'h2;
   localparam logic [PW-1:0] PRI_CRYPTO = 4'h3;
   localparam logic [PW-1:0] PRI_ANALOG = 4'h4;
   localparam logic [PW-1:0] PRI_ASYNC = 4'h5;
   localparam logic [PW-1:0] PRI_TWOWIRE = 4'h6;
   localparam logic [PW-1:0] PRI_MIC = 4'h7;
   localparam logic [PW-1:0] PRI_PWM = 4'h8;
   // ahb transfer codes
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   typedef enum logic [1:0] {CH_IDLE, CH_ADDR, CH_DATA} dca_ch_st_t;
endpackage

// file: dca_arbiter.sv
// fixed-priority arbiter for one ram slave port of the matrix
// assumes requests stay high while a master is mid-transaction
module dca_arbiter
   import dca_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // requests and grants, bit i is master level i
   input wire logic [dca_pkg::NPRI-1:0] i_req,
   input wire logic [dca_pkg::NPRI-1:0] i_active,
   output logic [dca_pkg::NPRI-1:0] o_gnt
);
   import dca_pkg::*;
   typedef struct packed {
      logic [NPRI-1:0] gnt;
   } dca_arb_s_t;
   dca_arb_s_t s_q, s_d;
   // ----------------------------------------------------------------
   // grant selection
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.gnt = '0;
      // owner keeps slave while active and unchallenged; a lender gives it back
      if (|(s_q.gnt & i_req & i_active) && !(|(i_req & (s_q.gnt - 1'b1)))) begin
         s_d.gnt = s_q.gnt;
      end else begin
         for (int i = NPRI - 1; i >= 0; i--) begin
            if (i_req[i]) begin
               s_d.gnt = '0;
               s_d.gnt[i] = 1'b1;
            end
         end
      end
      if (!i_rst_n) begin
         s_d.gnt = '0;
      end
   end
   always_ff @(posedge i_clk) begin
      s_q <= s_d;
   end
   assign o_gnt = s_q.gnt;
   a_gnt_onehot: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $onehot0(o_gnt)) else $error("more than one grant");
endmodule

// file: dca_channel.sv
// one byte-granular dma channel acting as an ahb master
// assumes a single-layer byte path to a ram slave port
module dca_channel
   import dca_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // settings
   input wire logic i_wr_dir,
   input wire logic i_list_cap,
   input wire logic i_list_en,
   input wire logic [dca_pkg::AW-1:0] i_ptr,
   input wire logic [dca_pkg::CW-1:0] i_max,
   input wire logic i_start,
   input wire logic i_drop,
   // peripheral side bytes
   input wire logic i_pv,
   input wire logic [7:0] i_pdata,
   input wire logic i_pend,
   output logic o_pready,
   output logic o_rv,
   output logic [7:0] o_rdata,
   // bus side
   output logic o_req,
   input wire logic i_gnt,
   output logic [dca_pkg::AW-1:0] o_haddr,
   output logic o_hwrite,
   output logic [7:0] o_hwdata,
   input wire logic [7:0] i_hrdata,
   // status
   output logic o_busy,
   output logic o_done,
   output logic o_lost,
   output logic [dca_pkg::CW-1:0] o_transferred_count
);
   import dca_pkg::*;
   typedef struct packed {
      dca_ch_st_t st;
      logic [AW-1:0] base;
      logic [CW-1:0] idx;
      logic [CW-1:0] amt;
      logic [7:0] wb;
      logic done;
      logic lost;
   } dca_ch_s_t;
   dca_ch_s_t s_q, s_d;
   logic in_ram;
   assign in_ram = (i_ptr >= RAM_BASE) && (i_ptr <= RAM_LIMIT);
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.lost = 1'b0;
      unique case (s_q.st)
         CH_IDLE: begin
            if (i_start && in_ram) begin
               s_d.st = CH_ADDR;
               s_d.base = i_ptr;
               s_d.idx = '0;
               s_d.amt = '0;
            end
         end
         CH_ADDR: begin
            if (s_q.idx == i_max) begin
               if (i_list_cap && i_list_en && !i_pend) begin
                  s_d.base = s_q.base + AW'(i_max);
                  s_d.idx = '0;
               end else begin
                  s_d.st = CH_IDLE;
                  s_d.done = 1'b1;
               end
            end else if (i_wr_dir && i_pend) begin
               s_d.st = CH_IDLE;
               s_d.done = 1'b1;
            end else if (!i_wr_dir || i_pv) begin
               if (i_gnt) begin
                  s_d.wb = i_pdata;
                  s_d.st = CH_DATA;
               end else if (i_wr_dir && i_drop) begin
                  s_d.lost = 1'b1;
               end
            end
         end
         CH_DATA: begin
            s_d.st = CH_ADDR;
            s_d.idx = s_q.idx + 1'b1;
            s_d.amt = s_q.amt + 1'b1;
         end
      endcase
      if (!i_rst_n) begin
         s_d = '0;
      end
   end
   always_ff @(posedge i_clk) begin
      s_q <= s_d;
   end
   assign o_req = (s_q.st == CH_ADDR) && (s_q.idx != i_max) && (!i_wr_dir || i_pv);
   assign o_haddr = s_q.base + AW'(s_q.idx);
   assign o_hwrite = i_wr_dir;
   assign o_hwdata = (s_q.st == CH_ADDR) ? i_pdata : s_q.wb;
   assign o_pready = i_wr_dir && (s_q.st == CH_ADDR) && (s_q.idx != i_max)
                     && (i_gnt || i_drop);
   assign o_rv = !i_wr_dir && (s_q.st == CH_DATA);
   assign o_rdata = i_hrdata;
   assign o_busy = (s_q.st != CH_IDLE);
   assign o_done = s_q.done;
   assign o_lost = s_q.lost;
   assign o_transferred_count = s_q.amt;
   a_cnt_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_q.idx <= i_max || s_q.st == CH_IDLE) else $error("count beyond maximum");
endmodule

// file: dca_ram_model.sv
// ram slave model standing on the ram slave port of the dma block
// assumes byte beats with write data beside the address phase
module dca_ram_model
   import dca_pkg::*;
(
   // clock
   input wire logic i_clk,
   // ram slave port
   input wire logic [1:0] i_htrans,
   input wire logic [dca_pkg::AW-1:0] i_haddr,
   input wire logic i_hwrite,
   input wire logic [7:0] i_hwdata,
   output logic [7:0] o_hrdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // byte storage, read data one cycle after the address phase
   // ----------------------------------------------------------------
   logic [7:0] mem [0:63];
   initial o_hrdata = 8'h00;
   always @(posedge i_clk) begin
      if (i_htrans == HTRANS_NONSEQ && i_hwrite) begin
         mem[i_haddr[5:0]] <= i_hwdata;
      end
      if (i_htrans == HTRANS_NONSEQ && !i_hwrite) begin
         o_hrdata <= mem[i_haddr[5:0]];
      end else begin
         o_hrdata <= ~o_hrdata;
      end
   end
endmodule

// file: dca_top_test.sv
// self-checking bench for the dma channel and arbiter top
// assumes the ram model on the ram slave port and one 125 MHz clock
module dca_top_test;
   import dca_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("FAIL %0t: value mismatch", $time); end end
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wr_byte = 8'h00;
   logic [DW-1:0] i_wdata = 32'h0000_0000, o_rdata;
   logic o_rd_valid, o_wr_ready, o_hwrite, o_rd_done, o_wr_done, o_wr_lost;
   logic [7:0] o_rd_byte, o_hwdata, hrdata;
   logic i_wr_valid = 1'b0, i_wr_end = 1'b0, rd_pend = 1'b0;
   logic [NPRI-1:0] i_oth_req = 9'h000, i_oth_active = 9'h000, o_oth_gnt;
   logic [1:0] o_htrans;
   logic [AW-1:0] o_haddr;
   logic [2:0] o_hsize;
   logic [31:0] seed = 32'h0000_003C;
   logic [7:0] wb [0:15];
   logic [7:0] s4, s11;
   logic [DW-1:0] rd_q [$];
   logic [7:0] by_q [$];
   logic [39:0] bt_q [$];
   int bad_count = 0, n_tests = 0, wk = 0, nend = -1, lost_n = 0, lv, n;
   always #4 i_clk = ~i_clk;
   dca_top u_dca_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
      .o_rd_byte(o_rd_byte), .i_wr_valid(i_wr_valid), .i_wr_byte(i_wr_byte),
      .i_wr_end(i_wr_end), .o_wr_ready(o_wr_ready), .i_oth_req(i_oth_req),
      .i_oth_active(i_oth_active), .o_oth_gnt(o_oth_gnt), .o_htrans(o_htrans),
      .o_haddr(o_haddr), .o_hwrite(o_hwrite), .o_hsize(o_hsize), .o_hwdata(o_hwdata),
      .i_hrdata(hrdata), .o_rd_done(o_rd_done), .o_wr_done(o_wr_done), .o_wr_lost(o_wr_lost));
   dca_ram_model u_dca_ram_model (.i_clk(i_clk), .i_htrans(o_htrans), .i_haddr(o_haddr),
      .i_hwrite(o_hwrite), .i_hwdata(o_hwdata), .o_hrdata(hrdata));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      rd_q.push_back(e);
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask
   task automatic wait_done(input bit wr);
      int k;
      for (k = 0; k < 400; k++) begin
         @(posedge i_clk);
         if ((wr ? o_wr_done : o_rd_done) === 1'b1) break;
      end
      `CHK(k < 400, 1'b1)
   endtask
   task automatic rd_expect(input logic [31:0] b, input int c);
      int k;
      for (k = 0; k < c; k++) by_q.push_back(u_dca_ram_model.mem[(b[5:0] + k) & 63]);
   endtask
   task automatic arb(input logic [8:0] rq, input logic [8:0] ac, input logic [8:0] ex);
      int k;
      i_oth_req <= rq;
      i_oth_active <= ac;
      for (k = 0; k < 8 && o_oth_gnt !== ex; k++) @(posedge i_clk);
      `CHK(o_oth_gnt, ex)
   endtask
   task automatic do_write(input logic [31:0] ptr, input int mx, input int ne);
      int k;
      for (k = 0; k < 16; k++) begin
         wb[k] = seed[7:0];
         seed = xs(seed);
      end
      for (k = 0; k < ((ne < mx) ? ne : mx); k++) bt_q.push_back({ptr + k, wb[k]});
      wk = 0;
      nend = ne;
      i_wr_byte <= wb[0];
      i_wr_valid <= (ne > 0);
      i_wr_end <= (ne == 0);
      reg_wr(WR_PTR_OFS, ptr);
      reg_wr(WR_MAX_OFS, 32'(mx));
      reg_wr(CTRL_OFS, 32'h0000_0002);
      wait_done(1'b1);
      i_wr_valid <= 1'b0;
      i_wr_end <= 1'b0;
      reg_rd(WR_AMT_OFS, 32'((ne < mx) ? ne : mx));
      `CHK(bt_q.size(), 0)
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // output watcher
   // ----------------------------------------------------------------
   always @(posedge i_clk) begin
      rd_pend <= i_rd;
      if (rd_pend) `CHK(o_rdata, rd_q.pop_front())
      if (o_rd_valid === 1'b1) `CHK(o_rd_byte, by_q.pop_front())
      if (o_wr_lost === 1'b1) lost_n++;
      if (o_htrans === HTRANS_NONSEQ) begin
         `CHK(o_haddr >= RAM_BASE && o_haddr <= RAM_LIMIT, 1'b1)
         `CHK(o_hsize, HSIZE_BYTE)
         if (o_hwrite === 1'b1 && nend >= 0) begin
            `CHK({o_haddr, o_hwdata}, bt_q.pop_front())
            wk <= wk + 1;
            i_wr_byte <= wb[(wk + 1) & 15];
            i_wr_end <= (wk + 1 >= nend);
         end
      end
   end
   initial begin
      #60_000;
      bad_count++;
      tally_and_finish();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      for (n = 0; n < 64; n++) begin
         u_dca_ram_model.mem[n] = seed[7:0];
         seed = xs(seed);
      end
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      reg_rd(RD_PTR_OFS, PTR_RST);
      reg_rd(RD_MAX_OFS, 32'(CNT_RST));
      reg_wr(8'h30, 32'hFFFF_FFFF);
      reg_rd(8'h30, 32'h0000_0000);
      reg_wr(CTRL_OFS, 32'h0000_0001);
      repeat (20) @(posedge i_clk);
      reg_rd(STAT_OFS, 32'h0000_0000);
      rd_expect(32'h2000_0000, 5);
      reg_wr(RD_PTR_OFS, 32'h2000_0000);
      reg_wr(RD_MAX_OFS, 32'h0000_0005);
      i_oth_req <= 9'h001;
      i_oth_active <= 9'h001;
      reg_wr(CTRL_OFS, 32'h0000_0001);
      repeat (20) @(posedge i_clk);
      `CHK(by_q.size(), 5)
      `CHK(o_oth_gnt, 9'h001)
      i_oth_req <= 9'h000;
      i_oth_active <= 9'h000;
      wait_done(1'b0);
      `CHK(by_q.size(), 0)
      reg_rd(RD_AMT_OFS, 32'h0000_0005);
      s4 = u_dca_ram_model.mem[4];
      s11 = u_dca_ram_model.mem[11];
      do_write(32'h2000_0005, 6, 8);
      `CHK(u_dca_ram_model.mem[4], s4)
      `CHK(u_dca_ram_model.mem[11], s11)
      do_write(32'h2000_0020, 6, 0);
      rd_expect(32'h2000_0000, 12);
      reg_wr(RD_MAX_OFS, 32'h0000_0004);
      reg_wr(RD_LIST_OFS, 32'h0000_0001);
      reg_wr(CTRL_OFS, 32'h0000_0001);
      for (n = 0; n < 400 && by_q.size() > 4; n++) @(posedge i_clk);
      reg_wr(RD_LIST_OFS, 32'h0000_0000);
      wait_done(1'b0);
      repeat (20) @(posedge i_clk);
      `CHK(by_q.size(), 0)
      reg_rd(RD_PTR_OFS, 32'h2000_0000);
      for (lv = 0; lv < NPRI; lv++) begin
         if (lv == 1) continue;
         arb(~((9'h001 << lv) - 9'h001) & 9'h1FD, 9'h1FD, 9'h001 << lv);
      end
      arb(9'h011, 9'h011, 9'h001);
      arb(9'h010, 9'h011, 9'h010);
      arb(9'h011, 9'h011, 9'h001);
      arb(9'h000, 9'h000, 9'h000);
      nend = -1;
      reg_wr(WR_MAX_OFS, 32'h0000_0030);
      i_oth_req <= 9'h001;
      i_oth_active <= 9'h001;
      i_wr_valid <= 1'b1;
      reg_wr(CTRL_OFS, 32'h0000_0006);
      repeat (20) @(posedge i_clk);
      `CHK(lost_n > 0, 1'b1)
      `CHK(o_wr_ready, 1'b1)
      `CHK(o_htrans, HTRANS_IDLE)
      i_oth_req <= 9'h000;
      i_oth_active <= 9'h000;
      i_wr_end <= 1'b1;
      wait_done(1'b1);
      i_wr_valid <= 1'b0;
      i_wr_end <= 1'b0;
      reg_wr(CTRL_OFS, 32'h0000_0000);
      repeat (4) @(posedge i_clk);
      tally_and_finish();
   end
endmodule
